// ==== src/gpex_pkg.sv ====
// Purpose: shared constants and types of the eight-pin expander registers
// Assumes: 125 MHz core clock, command byte already decoded by the serial
//          front end into a register offset
// Notes:   one localparam per offset, reset value and timing count

package gpex_pkg;

  // ----------------------------------------------------------------------
  // register offsets (command byte values)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_PIN_STATE = 8'h00;
  localparam logic [7:0] OFF_OUTPUT_LEVEL = 8'h01;
  localparam logic [7:0] OFF_POLARITY = 8'h02;
  localparam logic [7:0] OFF_DIRECTION = 8'h03;
  localparam logic [7:0] OFF_PULLUP = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h05;
  localparam logic [7:0] OFF_HIZ = 8'h06;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h07;
  localparam logic [7:0] OFF_RISE_EN = 8'h08;
  localparam logic [7:0] OFF_FALL_EN = 8'h09;
  localparam logic [7:0] OFF_FILTER = 8'h0a;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_OUTPUT_LEVEL = 8'hff;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PULLUP_STD = 8'h00;
  localparam logic [7:0] RST_PULLUP_PU = 8'hff;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_HIZ = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_RISE_EN = 8'h00;
  localparam logic [7:0] RST_FALL_EN = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int FILT_REJECT_NS = 225;
  localparam int FILT_PASS_NS = 1075;
  // least time: round up, so 28 cycles (224 ns) never pass
  localparam int FILT_CYC_I = (FILT_REJECT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] FILT_CYC = 5'(FILT_CYC_I);

  // ----------------------------------------------------------------------
  // register access request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpex_req_t;

endpackage

// ==== src/gpex_regs.sv ====
// Purpose: register file, pin drive, input filter and interrupt logic of
//          an eight-pin general-purpose i/o expander
// Assumes: serial slave front end presents one-cycle read/write strobes
//          with the register offset; pin inputs already synchronous
// Notes:   read data appears one cycle after the read strobe
//
// Overview of operation
// R1 - pin-state read returns input levels, inverted where polarity bit set
// R2 - every pin-state read clears pending input interrupts
// R3 - output pins read back the output-level register in pin state
// R4 - writes to the pin-state register change nothing
// R5 - bit 7 is pin 7, bit 0 is pin 0 in every register
// R6 - output pins drive their output-level bit
// R7 - output-level read returns the last value written
// R8 - polarity bit 1 reports inverted input, 0 the true level
// R9 - direction 0 is output, 1 input; all inputs after reset
// R10 - pull-up bit enables pull-up; reset value depends on variant
// R11 - interrupt enable 1 allows interrupts; cleared after reset
// R12 - output pins never raise interrupts
// R13 - three-state bit 1 floats the output pin
// R14 - read-only status register shows which inputs interrupted
// R15 - rising-edge enable allows interrupt on low-to-high
// R16 - falling-edge enable allows interrupt on high-to-low
// R17 - filter enable register resets to all ones
// R18 - filtered: pulses over 1075 ns pass, under 225 ns suppressed
// R19 - filter bit 0 lets any change interrupt
// R20 - both edge bits clear: either edge, clears on return to read level
// R21 - host sends command byte 0x00 to 0x0a after slave address
// R22 - interrupt output held low while any status bit set

`timescale 1ns/10ps

module gpex_regs
  import gpex_pkg::*;
#(
  parameter bit PULLUP_VARIANT = 1'b0
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // register access from the serial slave
  input wire gpex_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // pins
  input wire logic [7:0] io_pins_in,
  output logic [7:0] io_pins_out,
  output logic [7:0] io_pins_oe,
  output logic [7:0] pullup_en,
  // open-drain interrupt, active low
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // both edge bits clear means either edge
  function automatic logic [7:0] edge_ok(input logic [7:0] rise,
                                         input logic [7:0] fall,
                                         input logic [7:0] ren,
                                         input logic [7:0] fen);
    logic [7:0] both;
    both = ~ren & ~fen;
    edge_ok = (rise & (ren | both)) | (fall & (fen | both));
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] output_level_reg_r;
  logic [7:0] polarity_invert_reg_r;
  logic [7:0] direction_reg_r;
  logic [7:0] pullup_enable_reg_r;
  logic [7:0] irq_enable_reg_r;
  logic [7:0] hiz_control_reg_r;
  logic [7:0] irq_status_reg_r;
  logic [7:0] irq_status_reg_nxt;
  logic [7:0] rise_irq_enable_reg_r;
  logic [7:0] fall_irq_enable_reg_r;
  logic [7:0] glitch_filter_reg_r;

  logic [7:0] in_r;
  logic [7:0] filt_r;
  logic [7:0] filt_d_r;
  logic [7:0] snap_r;
  logic [4:0] fcnt_r [8];
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] oe_r;
  logic irq_oe_r;

  logic rd_pin;
  logic [7:0] pin_state_val;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  assign rd_pin = req.rd && hit(req.addr, OFF_PIN_STATE);

  // ----------------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_level_reg_r <= RST_OUTPUT_LEVEL;
      polarity_invert_reg_r <= RST_POLARITY;
      direction_reg_r <= RST_DIRECTION; // R9
      pullup_enable_reg_r <= PULLUP_VARIANT ? RST_PULLUP_PU :
                             RST_PULLUP_STD; // R10
      irq_enable_reg_r <= RST_IRQ_ENABLE; // R11
      hiz_control_reg_r <= RST_HIZ;
      rise_irq_enable_reg_r <= RST_RISE_EN;
      fall_irq_enable_reg_r <= RST_FALL_EN;
      glitch_filter_reg_r <= RST_FILTER; // R17
    end else if (ce && req.wr) begin
      // pin-state and status offsets fall to default: no effect
      case (req.addr) // R4
        OFF_OUTPUT_LEVEL: output_level_reg_r <= req.wdata; // R7
        OFF_POLARITY: polarity_invert_reg_r <= req.wdata;
        OFF_DIRECTION: direction_reg_r <= req.wdata;
        OFF_PULLUP: pullup_enable_reg_r <= req.wdata;
        OFF_IRQ_ENABLE: irq_enable_reg_r <= req.wdata;
        OFF_HIZ: hiz_control_reg_r <= req.wdata;
        OFF_RISE_EN: rise_irq_enable_reg_r <= req.wdata;
        OFF_FALL_EN: fall_irq_enable_reg_r <= req.wdata;
        OFF_FILTER: glitch_filter_reg_r <= req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // inputs show the sampled level, outputs the written level, never the
  // pad, since a floated output would read back as noise
  assign pin_state_val =
    (direction_reg_r & (in_r ^ polarity_invert_reg_r)) | // R1 R8
    (~direction_reg_r & output_level_reg_r); // R3

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= RD_UNMAPPED;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rvalid_r <= req.rd;
      if (req.rd) begin
        case (req.addr)
          OFF_PIN_STATE: rdata_r <= pin_state_val;
          OFF_OUTPUT_LEVEL: rdata_r <= output_level_reg_r; // R7
          OFF_POLARITY: rdata_r <= polarity_invert_reg_r;
          OFF_DIRECTION: rdata_r <= direction_reg_r;
          OFF_PULLUP: rdata_r <= pullup_enable_reg_r;
          OFF_IRQ_ENABLE: rdata_r <= irq_enable_reg_r;
          OFF_HIZ: rdata_r <= hiz_control_reg_r;
          OFF_IRQ_STATUS: rdata_r <= irq_status_reg_r; // R14
          OFF_RISE_EN: rdata_r <= rise_irq_enable_reg_r;
          OFF_FALL_EN: rdata_r <= fall_irq_enable_reg_r;
          OFF_FILTER: rdata_r <= glitch_filter_reg_r;
          default: rdata_r <= RD_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oe_r <= 8'h00;
    end else if (ce) begin
      oe_r <= ~direction_reg_r & ~hiz_control_reg_r; // R6 R13
    end
  end

  // bit i of every vector maps to pin i
  assign io_pins_out = output_level_reg_r; // R5 R6
  assign io_pins_oe = oe_r;
  assign pullup_en = pullup_enable_reg_r; // R10
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // ----------------------------------------------------------------------
  // input sampling and glitch filter
  // ----------------------------------------------------------------------
  // a change must persist for the reject time before the filtered level
  // follows; cost is that slow pulses are delayed by that time too
  always_ff @(posedge core_clk) begin
    if (reset) begin
      in_r <= 8'h00;
      filt_r <= 8'h00;
      filt_d_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        fcnt_r[i] <= 5'h00;
      end
    end else if (ce) begin
      in_r <= io_pins_in;
      filt_d_r <= filt_r;
      for (int i = 0; i < 8; i++) begin
        if (!glitch_filter_reg_r[i]) begin
          filt_r[i] <= in_r[i]; // R19
          fcnt_r[i] <= 5'h00;
        end else if (in_r[i] == filt_r[i]) begin
          fcnt_r[i] <= 5'h00;
        end else if (fcnt_r[i] == FILT_CYC - 5'h01) begin
          filt_r[i] <= in_r[i]; // R18
          fcnt_r[i] <= 5'h00;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  always_comb begin
    set_v = direction_reg_r & irq_enable_reg_r & // R11 R12
            edge_ok(filt_r & ~filt_d_r, ~filt_r & filt_d_r,
                    rise_irq_enable_reg_r,
                    fall_irq_enable_reg_r); // R15 R16 R20
    if (rd_pin) begin
      clr_v = 8'hff; // R2
    end else begin
      clr_v = ~rise_irq_enable_reg_r & ~fall_irq_enable_reg_r &
              ~(filt_r ^ snap_r); // R20
    end
    // a new edge beats a clear in the same cycle
    irq_status_reg_nxt = set_v | (irq_status_reg_r & ~clr_v);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status_reg_r <= RST_IRQ_STATUS;
      snap_r <= 8'h00;
      irq_oe_r <= 1'b0;
    end else if (ce) begin
      irq_status_reg_r <= irq_status_reg_nxt; // R14
      irq_oe_r <= |irq_status_reg_nxt; // R22
      if (rd_pin) begin
        snap_r <= filt_r;
      end
    end
  end

  // open drain: only ever pulls low
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_oe_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_rd_inputs;
    ce && rd_pin |=> ((rdata & $past(direction_reg_r)) ==
      (($past(in_r) ^ $past(polarity_invert_reg_r)) &
       $past(direction_reg_r))) && rvalid;
  endproperty
  a_rd_inputs: assert property (p_rd_inputs) // R1
    else $error("pin state input bits wrong");

  property p_rd_outputs;
    ce && rd_pin |=> (rdata & ~$past(direction_reg_r)) ==
      ($past(output_level_reg_r) & ~$past(direction_reg_r));
  endproperty
  a_rd_outputs: assert property (p_rd_outputs) // R3
    else $error("pin state output bits wrong");

  property p_rd_clear;
    ce && rd_pin && (set_v == 8'h00) |=> irq_status_reg_r == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // R2
    else $error("status not cleared by pin state read");

  property p_ro_write;
    ce && req.wr && hit(req.addr, OFF_PIN_STATE) |=>
      $stable(output_level_reg_r) && $stable(direction_reg_r) &&
      $stable(hiz_control_reg_r) && $stable(irq_enable_reg_r);
  endproperty
  a_ro_write: assert property (p_ro_write) // R4
    else $error("pin state write changed a register");

  property p_ol_readback;
    ce && req.wr && hit(req.addr, OFF_OUTPUT_LEVEL) ##1 !req.wr ##1
      (ce && req.rd && hit(req.addr, OFF_OUTPUT_LEVEL) && !req.wr) |=>
      rdata == $past(req.wdata, 3);
  endproperty
  a_ol_readback: assert property (p_ol_readback) // R7
    else $error("output level readback wrong");

  property p_drive;
    ce && !direction_reg_r[0] && !hiz_control_reg_r[0] |=>
      io_pins_oe[0] && (io_pins_out[0] == output_level_reg_r[0]);
  endproperty
  a_drive: assert property (p_drive) // R6
    else $error("output pin not driven");

  property p_hiz;
    ce && hiz_control_reg_r[0] |=> !io_pins_oe[0];
  endproperty
  a_hiz: assert property (p_hiz) // R13
    else $error("three-stated pin still driven");

  property p_out_no_irq;
    ce |=> (irq_status_reg_r & ~$past(irq_status_reg_r) &
            ~$past(direction_reg_r)) == 8'h00;
  endproperty
  a_out_no_irq: assert property (p_out_no_irq) // R12
    else $error("output pin raised an interrupt");

  property p_filter_hold;
    glitch_filter_reg_r[0] && $past(glitch_filter_reg_r[0]) &&
      $changed(filt_r[0]) |->
      ($past(in_r[0], 8) == filt_r[0]) && ($past(in_r[0]) == filt_r[0]);
  endproperty
  a_filter_hold: assert property (p_filter_hold) // R18
    else $error("filter passed a short pulse");

  property p_no_filter;
    ce && !glitch_filter_reg_r[2] |=> filt_r[2] == $past(in_r[2]);
  endproperty
  a_no_filter: assert property (p_no_filter) // R19
    else $error("unfiltered input did not follow");

  property p_return_clear;
    ce && irq_status_reg_r[0] && !set_v[0] && !rise_irq_enable_reg_r[0] &&
      !fall_irq_enable_reg_r[0] && (filt_r[0] == snap_r[0]) |=>
      !irq_status_reg_r[0];
  endproperty
  a_return_clear: assert property (p_return_clear) // R20
    else $error("status not cleared on return to read level");

  property p_irq_pin;
    irq_n_oe == (irq_status_reg_r != 8'h00);
  endproperty
  a_irq_pin: assert property (p_irq_pin) // R22
    else $error("interrupt pin disagrees with status");

  property p_set_wins;
    ce && rd_pin && set_v[0] |=> irq_status_reg_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) // R14
    else $error("edge lost during clearing read");

  c_irq_raise: cover property (ce && set_v != 8'h00 ##1 irq_n_oe);
  c_read_clear: cover property (irq_n_oe ##1 ce && rd_pin ##1 !irq_n_oe);
  c_filter_pass: cover property (glitch_filter_reg_r[0] &&
                                 $changed(filt_r[0]));
  c_out_drive: cover property (io_pins_oe != 8'h00);

endmodule

// ==== test/gpex_host_model.sv ====
// Purpose: host-side register master model for the expander
// Assumes: the serial front end has turned each command byte into an
//          offset strobe; accesses are single and unpaced
// Notes:   drives at the falling edge, one strobe cycle per access
`timescale 1ns/10ps

module gpex_host_model
  import gpex_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output gpex_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);

  initial begin
    req = '0;
  end

  // released offset and data show the inverse of the last value, so a
  // design that samples them outside a strobe picks up garbage
  task automatic idle();
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge core_clk);
    idle();
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
    @(negedge core_clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge core_clk);
    d = rdata;
    v = rvalid;
    idle();
  endtask

endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench of the expander register block
// Assumes: ce high outside the freeze scenario; pads resolved here
// Notes:   each scenario but t_filter leaves pins as inputs with interrupts quiet
`timescale 1ns/10ps

module tb_top
  import gpex_pkg::*;
  ;

  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  gpex_req_t req;
  logic [7:0] rdata, io_pins_out, io_pins_oe, pullup_en;
  logic rvalid, irq_n_out, irq_n_oe;
  logic [7:0] ext_lvl = 8'h00;
  int mismatches = 0;
  int samples_checked = 0;
  // driven pads show the output level, floating ones the outside world
  wire logic [7:0] pad = (io_pins_oe & io_pins_out) | (~io_pins_oe & ext_lvl);
  // open-drain line with an outside pull-up
  wire logic irq_line_n = irq_n_oe ? irq_n_out : 1'b1;

  always #4 core_clk = ~core_clk;

  gpex_regs #(.PULLUP_VARIANT(1'b0)) DUT (
    .core_clk(core_clk), .reset(reset), .ce(ce), .req(req),
    .rdata(rdata), .rvalid(rvalid), .io_pins_in(pad),
    .io_pins_out(io_pins_out), .io_pins_oe(io_pins_oe),
    .pullup_en(pullup_en), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
  );

  gpex_host_model host (
    .core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid)
  );

  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd_reg(a, d, v);
    chk1(v, 1'b1);
    chk8(d, exp);
  endtask

  task automatic edge_chk(input logic lvl, input logic [7:0] exp);
    ext_lvl[0] = lvl;
    repeat (5) @(negedge core_clk);
    rd_chk(OFF_IRQ_STATUS, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] tab [1:10];
    tab = '{RST_OUTPUT_LEVEL, RST_POLARITY, RST_DIRECTION, RST_PULLUP_STD,
      RST_IRQ_ENABLE, RST_HIZ, RST_IRQ_STATUS, RST_RISE_EN, RST_FALL_EN,
      RST_FILTER};
    for (int a = 1; a <= 10; a++) begin
      rd_chk(8'(a), tab[a]);
    end
    rd_chk(8'h0b, RD_UNMAPPED);
    chk8(io_pins_oe, 8'h00);
    chk8(pullup_en, RST_PULLUP_STD);
    chk1(irq_line_n, 1'b1);
  endtask

  task automatic t_output();
    ext_lvl = 8'h3c;
    host.wr_reg(OFF_DIRECTION, 8'hf0);
    host.wr_reg(OFF_OUTPUT_LEVEL, 8'ha5);
    host.wr_reg(OFF_HIZ, 8'h01);
    host.wr_reg(OFF_PULLUP, 8'h5a);
    repeat (2) @(negedge core_clk);
    chk8(io_pins_out, 8'ha5);
    chk8(io_pins_oe, 8'h0e);
    chk8(pullup_en, 8'h5a);
    rd_chk(OFF_OUTPUT_LEVEL, 8'ha5);
    rd_chk(OFF_PIN_STATE, 8'h35);
    host.wr_reg(OFF_PIN_STATE, 8'hff);
    rd_chk(OFF_DIRECTION, 8'hf0);
    rd_chk(OFF_OUTPUT_LEVEL, 8'ha5);
    host.wr_reg(OFF_DIRECTION, 8'hff);
    host.wr_reg(OFF_HIZ, 8'h00);
  endtask

  task automatic t_polarity();
    host.wr_reg(OFF_POLARITY, 8'h81);
    rd_chk(OFF_PIN_STATE, 8'hbd);
    host.wr_reg(OFF_POLARITY, 8'h00);
    rd_chk(OFF_PIN_STATE, 8'h3c);
    ext_lvl = 8'h00;
  endtask

  task automatic t_both_edges();
    host.wr_reg(OFF_FILTER, 8'h00);
    host.wr_reg(OFF_IRQ_ENABLE, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h00);
    ext_lvl[0] = 1'b1;
    repeat (5) @(negedge core_clk);
    chk1(irq_line_n, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 8'h01);
    edge_chk(1'b0, 8'h00);
    chk1(irq_line_n, 1'b1);
    edge_chk(1'b1, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h01);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
  endtask

  task automatic t_single_edges();
    host.wr_reg(OFF_RISE_EN, 8'h01);
    edge_chk(1'b0, 8'h00);
    edge_chk(1'b1, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h01);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
    host.wr_reg(OFF_RISE_EN, 8'h00);
    host.wr_reg(OFF_FALL_EN, 8'h01);
    edge_chk(1'b0, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h00);
    edge_chk(1'b1, 8'h00);
    // falling edge lands in the very cycle of a clearing read
    ext_lvl[0] = 1'b0;
    @(negedge core_clk);
    rd_chk(OFF_PIN_STATE, 8'h00);
    rd_chk(OFF_IRQ_STATUS, 8'h01);
    edge_chk(1'b1, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h01);
  endtask

  task automatic t_output_no_irq();
    host.wr_reg(OFF_RISE_EN, 8'h01);
    host.wr_reg(OFF_DIRECTION, 8'hfe);
    host.wr_reg(OFF_OUTPUT_LEVEL, 8'h00);
    repeat (5) @(negedge core_clk);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
    host.wr_reg(OFF_OUTPUT_LEVEL, 8'hff);
    repeat (5) @(negedge core_clk);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
    host.wr_reg(OFF_DIRECTION, 8'hff);
    host.wr_reg(OFF_IRQ_ENABLE, 8'h00);
    edge_chk(1'b0, 8'h00);
    edge_chk(1'b1, 8'h00);
    host.wr_reg(OFF_RISE_EN, 8'h00);
    host.wr_reg(OFF_FALL_EN, 8'h00);
    host.wr_reg(OFF_IRQ_ENABLE, 8'h01);
  endtask

  task automatic t_filter();
    host.wr_reg(OFF_FILTER, 8'h01);
    rd_chk(OFF_PIN_STATE, 8'h01);
    // 160 ns low pulse, below the rejection limit
    ext_lvl[0] = 1'b0;
    repeat (20) @(negedge core_clk);
    ext_lvl[0] = 1'b1;
    repeat (40) @(negedge core_clk);
    rd_chk(OFF_IRQ_STATUS, 8'h00);
    // 1080 ns low, past the pass limit
    ext_lvl[0] = 1'b0;
    repeat (135) @(negedge core_clk);
    chk1(irq_line_n, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 8'h01);
  endtask

  task automatic t_restart();
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
  endtask

  task automatic t_freeze();
    ce = 1'b0;
    host.wr_reg(OFF_OUTPUT_LEVEL, 8'h0f);
    ce = 1'b1;
    rd_chk(OFF_OUTPUT_LEVEL, RST_OUTPUT_LEVEL);
    host.wr_reg(OFF_OUTPUT_LEVEL, 8'h0f);
    rd_chk(OFF_OUTPUT_LEVEL, 8'h0f);
  endtask

  initial begin
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_output();
    t_polarity();
    t_both_edges();
    t_single_edges();
    t_output_no_irq();
    t_filter();
    t_restart();
    t_freeze();
    tally_and_finish();
  end

  // whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

endmodule
